// >>> core/sfsr_cmd.sv
// Serial flash command decoder: write enable latch, status access, reads.
// Assumes flash_sck and flash_cs_n arrive from a host on another clock,
// a serial clock well below clk_sys / 4, and a flat array port whose
// mem_data follows mem_addr combinationally on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "sfsr_map.svh"
// Summary of operation
// - Opcode 06h sets write enable latch
// - 50h arms volatile-only status write, latch untouched
// - Opcode 04h clears write enable latch
// - Latch clears at power-up and write completion
// - 05h/35h return status, even while busy
// - Status shifts MSB first, repeats until deselect
// - 01h writes only the writable status bits
// - Status write needs exactly 8 or 16 bits
// - Eight-bit 01h clears second-register writable bits
// - Valid non-volatile status write runs timed busy cycle
// - Busy start clears write enable latch
// - 31h writes second-register bits, needs latch or 50h
// - Single-wire 03h streams bytes with address auto-increment
// - Normal read ignored while busy
// - 0Bh address, dummy clocks, then falling-edge data
// - Four-wire dummy count 4/6/8 from C0h
// - Dummy count defaults to 4 after reset
// - Single-wire 3Bh: eight dummies, then two bits per clock
// - Quad output: IO3..IO0 carry high nibble first
// - Dual output: IO1/IO0 carry bit pairs, high first
// - All fields travel most significant bit first
module sfsr_cmd
  import sfsr_pkg::*;
#(
  parameter int unsigned STATUS_WRITE_CYCLES = `SFSR_T_STATUS_WRITE_US * `SFSR_CLK_MHZ
)(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        flash_sck,
  input  wire logic        flash_cs_n,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe_n,
  input  wire logic        four_wire_command_mode,
  output logic      [23:0] mem_addr,
  input  wire logic [7:0]  mem_data,
  output logic             write_enable_latch,
  output logic             quad_enable,
  output logic             busy
);
  typedef struct packed {
    sfsr_phase_t phase;
    logic        sck_prev;
    logic        cs_prev;
    sfsr_lanes_t in_lanes;
    sfsr_lanes_t out_lanes;
    logic [7:0]  opcode;
    logic [23:0] sh;
    logic [5:0]  cnt;
    logic [4:0]  data_bits;
    logic [3:0]  dummy_left;
    logic [7:0]  out_sr;
    logic [2:0]  out_left;
    logic        from_status;
    logic        status_sel2;
    logic [23:0] mem_addr;
    sfsr_io_t    io;
    logic        we_latch;
    logic        vol_armed;
    logic        rst_armed;
    logic [1:0]  dummy_sel;
    sfsr_stat_t  nv;
    sfsr_stat_t  act;
    sfsr_stat_t  pend;
    logic        sw_start;
  } sfsr_state_t;

  localparam sfsr_state_t ST_RESET = '{
    phase: PH_IDLE, sck_prev: 1'b1, cs_prev: 1'b1,
    in_lanes: LN_SINGLE, out_lanes: LN_SINGLE,
    io: '{dout: 4'h0, oe_n: `SFSR_OE_NONE},
    dummy_sel: `SFSR_PARAM_DUMMY_DEF,
    nv: '{sr1: `SFSR_SR1_RESET, sr2: `SFSR_SR2_RESET},
    act: '{sr1: `SFSR_SR1_RESET, sr2: `SFSR_SR2_RESET},
    pend: '{sr1: `SFSR_SR1_RESET, sr2: `SFSR_SR2_RESET},
    default: '0
  };

  sfsr_state_t s_q;
  sfsr_state_t s_d;
  logic [5:0]  pins;
  logic        sck_s;
  logic        cs_n_s;
  logic [3:0]  io_s;
  logic        timer_busy;
  logic        timer_done;
  sfsr_sync u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .raw     ({io_in, flash_cs_n, flash_sck}),
    .synced  (pins)
  );
  sfsr_busy_timer #(
    .CYCLES (STATUS_WRITE_CYCLES)
  ) u_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .start   (s_q.sw_start),
    .busy    (timer_busy),
    .done    (timer_done)
  );
  assign sck_s  = pins[0];
  assign cs_n_s = pins[1];
  assign io_s   = pins[5:2];
  function automatic logic [5:0] lane_w(sfsr_lanes_t ln);
    unique case (ln)
      LN_SINGLE: lane_w = 6'h1;
      LN_DUAL:   lane_w = 6'h2;
      LN_QUAD:   lane_w = 6'h4;
    endcase
  endfunction : lane_w
  // Incoming bits enter at the bottom so the first bit ends up highest
  function automatic logic [23:0] shift_in(logic [23:0] sh, logic [3:0] io, sfsr_lanes_t ln);
    if (ln == LN_QUAD) begin
      shift_in = {sh[19:0], io};
    end else begin
      shift_in = {sh[22:0], io[0]};
    end
  endfunction : shift_in
  function automatic logic [3:0] dummy_of(logic [1:0] sel);
    unique case (sel)
      `SFSR_PARAM_DUMMY_DEF: dummy_of = `SFSR_DUMMY_FOUR;
      `SFSR_PARAM_DUMMY_SIX: dummy_of = `SFSR_DUMMY_SIX;
      default:               dummy_of = `SFSR_DUMMY_EIGHT;
    endcase
  endfunction : dummy_of
  function automatic logic [2:0] chunks_left(sfsr_lanes_t ln);
    unique case (ln)
      LN_SINGLE: chunks_left = `SFSR_LEFT_SINGLE;
      LN_DUAL:   chunks_left = `SFSR_LEFT_DUAL;
      LN_QUAD:   chunks_left = `SFSR_LEFT_QUAD;
    endcase
  endfunction : chunks_left
  // Top bits of b go out; single data uses IO1 as the serial output
  function automatic sfsr_io_t drive(sfsr_lanes_t ln, logic [7:0] b);
    sfsr_io_t r;
    r.dout = 4'h0;
    r.oe_n = `SFSR_OE_NONE;
    unique case (ln)
      LN_SINGLE: begin
        r.dout[1] = b[7];
        r.oe_n    = `SFSR_OE_SINGLE;
      end
      LN_DUAL: begin
        r.dout[1:0] = b[7:6];
        r.oe_n      = `SFSR_OE_DUAL;
      end
      LN_QUAD: begin
        r.dout = b[7:4];
        r.oe_n = `SFSR_OE_QUAD;
      end
    endcase
    return r;
  endfunction : drive
  function automatic logic [7:0] status_byte(logic sel2, sfsr_stat_t a, logic latch, logic bsy);
    logic [7:0] v;
    v = a.sr1 & `SFSR_SR1_WR_MASK;
    v[`SFSR_SR1_LATCH_BIT] = latch;
    v[`SFSR_SR1_BUSY_BIT]  = bsy;
    status_byte = sel2 ? (a.sr2 & `SFSR_SR2_WR_MASK) : v;
  endfunction : status_byte
  always_comb begin
    logic        rise;
    logic        fall;
    logic [5:0]  cnt_nx;
    logic [23:0] sh_nx;
    logic [7:0]  byte_v;
    logic        enabled;
    logic        len_ok;
    sfsr_stat_t  new_st;
    rise    = sck_s & ~s_q.sck_prev;
    fall    = ~sck_s & s_q.sck_prev;
    cnt_nx  = s_q.cnt + lane_w(s_q.in_lanes);
    sh_nx   = shift_in(s_q.sh, io_s, s_q.in_lanes);
    byte_v  = 8'h00;
    enabled = s_q.we_latch | s_q.vol_armed;
    len_ok  = 1'b0;
    new_st  = s_q.act;

    s_d          = s_q;
    s_d.sck_prev = sck_s;
    s_d.cs_prev  = cs_n_s;
    s_d.sw_start = 1'b0;

    if (timer_done) begin
      s_d.nv  = s_q.pend;
      s_d.act = s_q.pend;
      s_d.we_latch = 1'b0;
    end

    if (cs_n_s) begin
      if (!s_q.cs_prev && s_q.phase == PH_DIN) begin
        s_d.rst_armed = (s_q.opcode == `SFSR_OP_RESET_ENABLE);
        if (s_q.opcode != `SFSR_OP_VOL_ENABLE) begin
          s_d.vol_armed = 1'b0;
        end
        unique case (s_q.opcode)
          `SFSR_OP_WR_ENABLE: if (s_q.data_bits == `SFSR_DATA_NONE) s_d.we_latch = 1'b1;
          `SFSR_OP_WR_DISABLE: if (s_q.data_bits == `SFSR_DATA_NONE) s_d.we_latch = 1'b0;
          `SFSR_OP_VOL_ENABLE: if (s_q.data_bits == `SFSR_DATA_NONE) s_d.vol_armed = 1'b1;
          `SFSR_OP_RESET: begin
            if (s_q.rst_armed && !timer_busy) begin
              s_d.dummy_sel = `SFSR_PARAM_DUMMY_DEF;
              s_d.act       = s_q.nv;
            end
          end
          `SFSR_OP_WR_STATUS, `SFSR_OP_WR_STATUS2: begin
            if (s_q.opcode == `SFSR_OP_WR_STATUS) begin
              len_ok = (s_q.data_bits == `SFSR_DATA_ONE_BYTE) ||
                       (s_q.data_bits == `SFSR_DATA_TWO_BYTES);
              if (s_q.data_bits == `SFSR_DATA_TWO_BYTES) begin
                new_st.sr1 = s_q.sh[15:8] & `SFSR_SR1_WR_MASK;
                new_st.sr2 = s_q.sh[7:0] & `SFSR_SR2_WR_MASK;
              end else begin
                new_st.sr1 = s_q.sh[7:0] & `SFSR_SR1_WR_MASK;
                new_st.sr2 = `SFSR_SR2_RESET;
              end
            end else begin
              len_ok     = (s_q.data_bits == `SFSR_DATA_ONE_BYTE);
              new_st.sr2 = s_q.sh[7:0] & `SFSR_SR2_WR_MASK;
            end
            // Writes during a running cycle are dropped rather than queued
            if (len_ok && enabled && !timer_busy) begin
              if (s_q.vol_armed) begin
                s_d.act = new_st;
              end else begin
                s_d.pend     = new_st;
                s_d.sw_start = 1'b1;
                s_d.we_latch = 1'b0;
              end
            end
          end
          default: begin
          end
        endcase
      end
      s_d.phase   = PH_IDLE;
      s_d.io.oe_n = `SFSR_OE_NONE;
    end else begin
      unique case (s_q.phase)
        PH_IDLE: begin
          s_d.phase     = PH_OP;
          s_d.cnt       = 6'h0;
          s_d.data_bits = `SFSR_DATA_NONE;
          s_d.in_lanes  = four_wire_command_mode ? LN_QUAD : LN_SINGLE;
          s_d.out_left  = 3'h0;
        end
        PH_OP: begin
          if (rise) begin
            s_d.sh  = sh_nx;
            s_d.cnt = cnt_nx;
            if (cnt_nx == `SFSR_OP_BITS) begin
              s_d.opcode      = sh_nx[7:0];
              s_d.cnt         = 6'h0;
              s_d.phase       = PH_DIN;
              s_d.out_lanes   = four_wire_command_mode ? LN_QUAD : LN_SINGLE;
              s_d.from_status = 1'b0;
              s_d.dummy_left  = `SFSR_DUMMY_NONE;
              unique case (sh_nx[7:0])
                `SFSR_OP_RD_STATUS1, `SFSR_OP_RD_STATUS2: begin
                  s_d.phase       = PH_OUT;
                  s_d.from_status = 1'b1;
                  s_d.status_sel2 = (sh_nx[7:0] == `SFSR_OP_RD_STATUS2);
                end
                `SFSR_OP_READ: begin
                  s_d.phase = (timer_busy || four_wire_command_mode) ? PH_SKIP : PH_ADDR;
                end
                `SFSR_OP_FAST_READ: begin
                  s_d.phase      = timer_busy ? PH_SKIP : PH_ADDR;
                  s_d.dummy_left = four_wire_command_mode ? dummy_of(s_q.dummy_sel)
                                                          : `SFSR_DUMMY_SPI;
                end
                `SFSR_OP_DUAL_READ: begin
                  s_d.phase      = (timer_busy || four_wire_command_mode) ? PH_SKIP : PH_ADDR;
                  s_d.dummy_left = `SFSR_DUMMY_SPI;
                  s_d.out_lanes  = LN_DUAL;
                end
                default: begin
                end
              endcase
            end
          end
        end
        PH_ADDR: begin
          if (rise) begin
            s_d.sh  = sh_nx;
            s_d.cnt = cnt_nx;
            if (cnt_nx == `SFSR_ADDR_BITS) begin
              s_d.mem_addr = sh_nx;
              s_d.phase    = (s_q.dummy_left == `SFSR_DUMMY_NONE) ? PH_OUT : PH_DUMMY;
            end
          end
        end
        PH_DUMMY: begin
          if (rise) begin
            s_d.dummy_left = s_q.dummy_left - `SFSR_DUMMY_LAST;
            if (s_q.dummy_left == `SFSR_DUMMY_LAST) begin
              s_d.phase = PH_OUT;
            end
          end
        end
        PH_OUT: begin
          if (fall) begin
            if (s_q.out_left == 3'h0) begin
              if (s_q.from_status) begin
                byte_v = status_byte(s_q.status_sel2, s_q.act, s_q.we_latch, timer_busy);
              end else begin
                byte_v       = mem_data;
                s_d.mem_addr = s_q.mem_addr + 24'h1;
              end
              s_d.out_left = chunks_left(s_q.out_lanes);
            end else begin
              byte_v       = s_q.out_sr;
              s_d.out_left = s_q.out_left - 3'h1;
            end
            s_d.io     = drive(s_q.out_lanes, byte_v);
            s_d.out_sr = 8'(byte_v << lane_w(s_q.out_lanes));
          end
        end
        PH_DIN: begin
          if (rise) begin
            s_d.sh = sh_nx;
            if (s_q.data_bits < `SFSR_DATA_SATURATE) begin
              s_d.data_bits = s_q.data_bits + 5'(lane_w(s_q.in_lanes));
            end
            if (s_q.opcode == `SFSR_OP_SET_PARAM &&
                s_q.data_bits + 5'(lane_w(s_q.in_lanes)) == `SFSR_DATA_ONE_BYTE) begin
              s_d.dummy_sel = sh_nx[`SFSR_PARAM_DUMMY_MSB:`SFSR_PARAM_DUMMY_LSB];
            end
          end
        end
        PH_SKIP: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= ST_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign io_out             = s_q.io.dout;
  assign io_oe_n            = s_q.io.oe_n;
  assign mem_addr           = s_q.mem_addr;
  assign write_enable_latch = s_q.we_latch;
  assign quad_enable        = s_q.act.sr2[`SFSR_SR2_QUAD_BIT];
  assign busy               = timer_busy;
endmodule : sfsr_cmd
`default_nettype wire

// >>> core/sfsr_map.svh
// Named constants for the serial flash status and read command decoder.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SFSR_MAP_SVH
`define SFSR_MAP_SVH

// Opcodes
`define SFSR_OP_WR_ENABLE     8'h06
`define SFSR_OP_WR_DISABLE    8'h04
`define SFSR_OP_VOL_ENABLE    8'h50
`define SFSR_OP_RD_STATUS1    8'h05
`define SFSR_OP_RD_STATUS2    8'h35
`define SFSR_OP_WR_STATUS     8'h01
`define SFSR_OP_WR_STATUS2    8'h31
`define SFSR_OP_READ          8'h03
`define SFSR_OP_FAST_READ     8'h0b
`define SFSR_OP_DUAL_READ     8'h3b
`define SFSR_OP_SET_PARAM     8'hc0
`define SFSR_OP_RESET_ENABLE  8'h66
`define SFSR_OP_RESET         8'h99

// Frame lengths in bits
`define SFSR_OP_BITS          6'h08
`define SFSR_ADDR_BITS        6'h18
`define SFSR_DATA_NONE        5'h00
`define SFSR_DATA_ONE_BYTE    5'h08
`define SFSR_DATA_TWO_BYTES   5'h10
`define SFSR_DATA_SATURATE    5'h11

// Dummy clocks
`define SFSR_DUMMY_NONE       4'h0
`define SFSR_DUMMY_LAST       4'h1
`define SFSR_DUMMY_SPI        4'h8
`define SFSR_DUMMY_FOUR       4'h4
`define SFSR_DUMMY_SIX        4'h6
`define SFSR_DUMMY_EIGHT      4'h8
`define SFSR_PARAM_DUMMY_DEF  2'h0
`define SFSR_PARAM_DUMMY_SIX  2'h1
`define SFSR_PARAM_DUMMY_LSB  4
`define SFSR_PARAM_DUMMY_MSB  5

// Status layout
`define SFSR_SR1_BUSY_BIT     0
`define SFSR_SR1_LATCH_BIT    1
`define SFSR_SR1_WR_MASK      8'hfc
`define SFSR_SR2_WR_MASK      8'h43
`define SFSR_SR2_QUAD_BIT     1
`define SFSR_SR1_RESET        8'h00
`define SFSR_SR2_RESET        8'h00

// Output lane enables, active low
`define SFSR_OE_NONE          4'hf
`define SFSR_OE_SINGLE        4'hd
`define SFSR_OE_DUAL          4'hc
`define SFSR_OE_QUAD          4'h0
`define SFSR_LEFT_SINGLE      3'h7
`define SFSR_LEFT_DUAL        3'h3
`define SFSR_LEFT_QUAD        3'h1

// Timing
`define SFSR_CLK_MHZ          20
`define SFSR_T_STATUS_WRITE_US 5000
`define SFSR_SYNC_RESET       6'h3f

`endif

// >>> core/sfsr_pkg.sv
// Types shared by the serial flash command decoder modules.
// Assumes sfsr_map.svh is on the include path.
`include "sfsr_map.svh"
package sfsr_pkg;

  typedef enum logic [2:0] {
    PH_IDLE, PH_OP, PH_ADDR, PH_DUMMY, PH_OUT, PH_DIN, PH_SKIP
  } sfsr_phase_t;

  typedef enum logic [1:0] {LN_SINGLE, LN_DUAL, LN_QUAD} sfsr_lanes_t;

  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] oe_n;
  } sfsr_io_t;

  typedef struct packed {
    logic [7:0] sr1;
    logic [7:0] sr2;
  } sfsr_stat_t;

endpackage : sfsr_pkg

// >>> core/sfsr_sync.sv
// Two-flop synchroniser for the serial clock, chip select and IO pins.
// Assumes the inputs are asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "sfsr_map.svh"
module sfsr_sync
  import sfsr_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [5:0] raw,
  output logic      [5:0] synced
);
  typedef struct packed {
    logic [5:0] meta;
    logic [5:0] stable;
  } sfsr_sync_st_t;

  sfsr_sync_st_t s_q;
  sfsr_sync_st_t s_d;

  always_comb begin
    s_d        = s_q;
    s_d.meta   = raw;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= {`SFSR_SYNC_RESET, `SFSR_SYNC_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign synced = s_q.stable;
endmodule : sfsr_sync
`default_nettype wire

// >>> core/sfsr_busy_timer.sv
// Self-timed write cycle timer: busy for CYCLES clocks after start.
// Assumes start is a one-cycle pulse from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module sfsr_busy_timer
  import sfsr_pkg::*;
#(
  parameter int unsigned CYCLES = 1
)(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  localparam logic [31:0] LOAD = (CYCLES > 1) ? 32'(CYCLES - 1) : 32'h0;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [31:0] cnt;
  } sfsr_timer_st_t;

  sfsr_timer_st_t s_q;
  sfsr_timer_st_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (s_q.busy) begin
      if (s_q.cnt == 32'h0) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - 32'h1;
      end
    end else if (start) begin
      s_d.busy = 1'b1;
      s_d.cnt  = LOAD;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign done = s_q.done;
endmodule : sfsr_busy_timer
`default_nettype wire

// >>> testbench/sfsr_cmd_assertions.sv
// Pin-level checks on the command decoder, bound to sfsr_cmd.
// Assumes it sees only the ports of sfsr_cmd, all on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module sfsr_cmd_assertions
  import sfsr_pkg::*;
#(
  parameter int unsigned CYCLES = 1
)(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        flash_sck,
  input wire logic        flash_cs_n,
  input wire logic [3:0]  io_in,
  input wire logic [3:0]  io_out,
  input wire logic [3:0]  io_oe_n,
  input wire logic        four_wire_command_mode,
  input wire logic [23:0] mem_addr,
  input wire logic [7:0]  mem_data,
  input wire logic        write_enable_latch,
  input wire logic        quad_enable,
  input wire logic        busy
);
  logic [31:0] bcnt_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !busy) begin
      bcnt_q <= 32'h0;
    end else begin
      bcnt_q <= bcnt_q + 32'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Six samples cover the synchroniser delay after a deselect
  sequence s_idle;
    flash_cs_n [*6];
  endsequence
  // Latch and status commands act only on deselect, so both hold inside a frame
  sequence s_frame;
    (!flash_cs_n && !busy) [*8];
  endsequence

  chk_oe_idle: assert property (s_idle |-> io_oe_n == 4'hf)
    else $error("outputs driven while deselected");
  chk_busy_latch: assert property ($rose(busy) |-> !write_enable_latch)
    else $error("latch still set when busy rose");
  chk_busy_min: assert property ($rose(busy) |-> busy [*8])
    else $error("busy cycle too short");
  chk_busy_max: assert property (busy |-> bcnt_q <= CYCLES + 2)
    else $error("busy cycle too long");
  chk_busy_start: assert property ($rose(busy) |-> flash_cs_n && $past(flash_cs_n))
    else $error("busy rose inside a frame");
  chk_wel_frame: assert property (s_frame |-> $stable(write_enable_latch))
    else $error("latch moved inside a frame");
  chk_qe_frame: assert property (s_frame |-> $stable(quad_enable))
    else $error("quad enable moved inside a frame");
  chk_lane_spi: assert property (!four_wire_command_mode && io_oe_n != 4'hf
    |-> io_oe_n inside {4'hd, 4'hc})
    else $error("bad lane enable in single mode");
  chk_lane_quad: assert property (four_wire_command_mode
    |-> io_oe_n inside {4'hf, 4'h0})
    else $error("bad lane enable in four-wire mode");
endmodule : sfsr_cmd_assertions
`default_nettype wire

// >>> testbench/sfsr_host_model.sv
// Host controller model: frames chip select, makes the serial clock.
// Assumes clk_sys at 20 MHz; one serial clock is 8 clk_sys cycles.
`timescale 1ns/1ps
`default_nettype none
module sfsr_host_model
  import sfsr_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic [3:0] io_wire,
  output logic            sck,
  output logic            cs_n,
  output logic [3:0]      drv_d,
  output logic [3:0]      drv_en
);
  logic [31:0] rx_q;

  initial begin
    sck    = 1'b0;
    cs_n   = 1'b1;
    drv_d  = 4'h0;
    drv_en = 4'h0;
    rx_q   = 32'h0;
  end

  // Long gap lets the deselect land before the next frame
  task automatic select(input logic on);
    @(posedge clk_sys);
    cs_n   <= !on;
    drv_en <= 4'h0;
    repeat (8) @(posedge clk_sys);
  endtask : select

  // v is left-justified; w is lanes driven (0 = released), rw lanes read
  task automatic shift(input logic [31:0] v, input int n, input int w, input int rw);
    logic [31:0] s;
    int          i;
    s = v;
    for (i = 0; i < n; i++) begin
      @(posedge clk_sys);
      if (w == 1) begin
        drv_en <= 4'h1;
        drv_d  <= {3'h0, s[31]};
        s = s << 1;
      end else if (w == 4) begin
        drv_en <= 4'hf;
        drv_d  <= s[31:28];
        s = s << 4;
      end else begin
        drv_en <= 4'h0;
      end
      repeat (3) @(posedge clk_sys);
      sck <= 1'b1;
      repeat (3) @(posedge clk_sys);
      // Sampled late in the high phase, well after the output settles
      if (rw == 1) rx_q <= {rx_q[30:0], io_wire[1]};
      else if (rw == 2) rx_q <= {rx_q[29:0], io_wire[1:0]};
      else rx_q <= {rx_q[27:0], io_wire};
      @(posedge clk_sys);
      sck <= 1'b0;
    end
  endtask : shift
endmodule : sfsr_host_model
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for sfsr_cmd driven through a host model.
// Assumes the design files, the checker and the host model compile first.
`timescale 1ns/1ps
`default_nettype none
module testbench import sfsr_pkg::*;;
  localparam int unsigned SWC = 400;
  logic        clk_sys, rst_n, fwm, flt_q, sck, cs_n, we_latch, quad_en, busy;
  logic [3:0]  io_out, io_oe_n, drv_d, drv_en;
  logic [23:0] mem_addr;
  logic [7:0]  mem_data;
  wire  [3:0]  io_wire;
  int          n_errors, n_checks, cyc;

  function automatic logic [7:0] mbyte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'ha5;
  endfunction : mbyte

  // Released lines toggle so a stale level never reads as data
  assign io_wire  = (~io_oe_n & io_out) | (io_oe_n & drv_en & drv_d)
                  | (io_oe_n & ~drv_en & {4{flt_q}});
  assign mem_data = mbyte(mem_addr);

  sfsr_cmd #(.STATUS_WRITE_CYCLES(SWC)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .flash_sck(sck), .flash_cs_n(cs_n),
    .io_in(io_wire), .io_out(io_out), .io_oe_n(io_oe_n),
    .four_wire_command_mode(fwm), .mem_addr(mem_addr), .mem_data(mem_data),
    .write_enable_latch(we_latch), .quad_enable(quad_en), .busy(busy));
  sfsr_host_model host (.clk_sys(clk_sys), .io_wire(io_wire), .sck(sck),
    .cs_n(cs_n), .drv_d(drv_d), .drv_en(drv_en));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk_sys) begin
    flt_q <= ~flt_q;
    cyc   <= cyc + 1;
    if (cyc == 30000) begin
      n_errors = n_errors + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cmd(input int w, input logic [7:0] op, input logic [31:0] arg,
                     input int na, input int nd, input int no, input int rw);
    host.select(1'b1);
    host.shift({op, 24'h0}, 8 / w, w, rw);
    if (na > 0) host.shift(arg, na, w, rw);
    if (nd > 0) host.shift(32'h0, nd, 0, rw);
    if (no > 0) host.shift(32'h0, no, 0, rw);
    host.select(1'b0);
  endtask : cmd

  task automatic wait_idle;
    int k;
    for (k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge clk_sys);
    chk(busy, 1'b0);
  endtask : wait_idle

  task automatic t_latch;
    chk(we_latch, 1'b0);
    chk(io_oe_n, 4'hf);
    cmd(1, 8'h06, 0, 0, 0, 0, 1);
    chk(we_latch, 1'b1);
    cmd(1, 8'h04, 0, 0, 0, 0, 1);
    chk(we_latch, 1'b0);
  endtask : t_latch

  task automatic t_wsr16;
    cmd(1, 8'h06, 0, 0, 0, 0, 1);
    cmd(1, 8'h01, 32'hffff_0000, 16, 0, 0, 1);
    chk(we_latch, 1'b0);
    chk(busy, 1'b1);
    cmd(1, 8'h05, 0, 0, 0, 16, 1);
    chk(host.rx_q[7:0], 8'h01);
    chk(host.rx_q[15:8], 8'h01);
    wait_idle();
    chk(we_latch, 1'b0);
    cmd(1, 8'h05, 0, 0, 0, 8, 1);
    chk(host.rx_q[7:0], 8'hfc);
    cmd(1, 8'h35, 0, 0, 0, 8, 1);
    chk(host.rx_q[7:0], 8'h43);
    chk(quad_en, 1'b1);
  endtask : t_wsr16

  task automatic t_wsr8_bad;
    cmd(1, 8'h06, 0, 0, 0, 0, 1);
    cmd(1, 8'h01, 32'h9c00_0000, 8, 0, 0, 1);
    wait_idle();
    cmd(1, 8'h35, 0, 0, 0, 8, 1);
    chk(host.rx_q[7:0], 8'h00);
    chk(quad_en, 1'b0);
    cmd(1, 8'h06, 0, 0, 0, 0, 1);
    cmd(1, 8'h01, 32'hfff0_0000, 12, 0, 0, 1);
    chk(busy, 1'b0);
    chk(we_latch, 1'b1);
    cmd(1, 8'h04, 0, 0, 0, 0, 1);
    cmd(1, 8'h01, 32'h0000_0000, 16, 0, 0, 1);
    chk(busy, 1'b0);
    cmd(1, 8'h05, 0, 0, 0, 8, 1);
    chk(host.rx_q[7:0], 8'h9c);
  endtask : t_wsr8_bad

  task automatic t_vol;
    // No write enable between the two frames
    cmd(1, 8'h50, 0, 0, 0, 0, 1);
    cmd(1, 8'h01, 32'h0002_0000, 16, 0, 0, 1);
    chk(busy, 1'b0);
    chk(we_latch, 1'b0);
    chk(quad_en, 1'b1);
    cmd(1, 8'h05, 0, 0, 0, 8, 1);
    chk(host.rx_q[7:0], 8'h00);
    cmd(1, 8'h06, 0, 0, 0, 0, 1);
    cmd(1, 8'h31, 32'hff00_0000, 8, 0, 0, 1);
    chk(busy, 1'b1);
    wait_idle();
    cmd(1, 8'h35, 0, 0, 0, 8, 1);
    chk(host.rx_q[7:0], 8'h43);
  endtask : t_vol

  task automatic t_read;
    cmd(1, 8'h03, 32'h0000_ff00, 24, 0, 16, 1);
    chk(host.rx_q[15:0], {mbyte(24'h0000ff), mbyte(24'h000100)});
    cmd(1, 8'h0b, 32'h1234_5600, 24, 8, 8, 1);
    chk(host.rx_q[7:0], mbyte(24'h123456));
    cmd(1, 8'h3b, 32'habcd_ef00, 24, 8, 8, 2);
    chk(host.rx_q[15:0], {mbyte(24'habcdef), mbyte(24'habcdf0)});
    cmd(1, 8'h06, 0, 0, 0, 0, 1);
    cmd(1, 8'h01, 32'h0002_0000, 16, 0, 0, 1);
    host.select(1'b1);
    host.shift({8'h03, 24'h0}, 8, 1, 1);
    host.shift(32'h0, 32, 0, 1);
    chk(io_oe_n, 4'hf);
    host.select(1'b0);
    wait_idle();
  endtask : t_read

  task automatic t_quad;
    logic [7:0] prm [2];
    int         dum [2];
    int         i;
    prm = '{8'h10, 8'h20};
    dum = '{6, 8};
    @(posedge clk_sys);
    fwm <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cmd(4, 8'h0b, 32'h0001_0200, 6, 4, 4, 4);
    chk(host.rx_q[15:0], {mbyte(24'h000102), mbyte(24'h000103)});
    for (i = 0; i < 2; i++) begin
      cmd(4, 8'hc0, {prm[i], 24'h0}, 2, 0, 0, 4);
      cmd(4, 8'h0b, 32'h0001_0200, 6, dum[i], 4, 4);
      chk(host.rx_q[15:0], {mbyte(24'h000102), mbyte(24'h000103)});
    end
    cmd(4, 8'h66, 0, 0, 0, 0, 4);
    cmd(4, 8'h99, 0, 0, 0, 0, 4);
    // Wrap length bits ride in the seventh nibble; the decoder must shrug it off
    cmd(4, 8'h77, 32'h0000_0060, 8, 0, 0, 4);
    cmd(4, 8'h0b, 32'h00a0_5000, 6, 4, 2, 4);
    chk(host.rx_q[7:0], mbyte(24'h00a050));
    @(posedge clk_sys);
    fwm <= 1'b0;
  endtask : t_quad

  initial begin
    rst_n    = 1'b0;
    fwm      = 1'b0;
    flt_q    = 1'b0;
    n_errors = 0;
    n_checks = 0;
    cyc      = 0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_latch();
    t_wsr16();
    t_wsr8_bad();
    t_vol();
    t_read();
    t_quad();
    tally_and_finish();
  end
endmodule : testbench

bind sfsr_cmd sfsr_cmd_assertions #(.CYCLES(STATUS_WRITE_CYCLES)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .flash_sck(flash_sck), .flash_cs_n(flash_cs_n),
  .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n),
  .four_wire_command_mode(four_wire_command_mode), .mem_addr(mem_addr),
  .mem_data(mem_data), .write_enable_latch(write_enable_latch),
  .quad_enable(quad_enable), .busy(busy));
`default_nettype wire
